// ===== shared/startup_pkg.sv
/*
 Shared constants and state types for the transceiver start-up sequencer and its link-side partner.
 Assumes both ends run on their own 40 MHz SYS_CLK and meet through startup_if.
*/
package startup_pkg;
    // ------------------------------------------------------------
    // Bus and timing
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam logic [7:0] ULPI_IDLE = 8'h00;
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int REF_CLOCK_KHZ = 19200;
    localparam int LINK_CLOCK_KHZ = 60000;
    localparam int RESET_LOW_MIN_NS = 1000;
    localparam int RESET_LOW_MIN_CYC = (RESET_LOW_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int LOCK_EDGES_DEF = 16;
    localparam int REF_TIMEOUT_DEF = 8;
    localparam int CLK_HALF_LOCKED_DEF = 1;
    localparam int CLK_HALF_MIN_DEF = 4;
    localparam int REF_HALF_DEF = 1;
    localparam int STP_HOLD_EDGES = 2;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        PS_OFF = 6'h01, PS_STANDBY = 6'h02, PS_WAIT_LOCK = 6'h04,
        PS_WAIT_STP = 6'h08, PS_RUN = 6'h10, PS_LOWPWR = 6'h20
    } phy_state_t;

    typedef enum logic [6:0] {
        LS_HOLD = 7'h01, LS_START = 7'h02, LS_TURN = 7'h04, LS_ACTIVE = 7'h08,
        LS_SLEEP = 7'h10, LS_DOZE = 7'h20, LS_WAKE = 7'h40
    } link_state_t;
endpackage : startup_pkg

// ===== shared/startup_if.sv
/*
 Pins between the transceiver and the link controller, one modport per party.
 Assumes the bench joins both ends; the shared data wire is resolved here from the enables.
*/
`timescale 1ns/1ps
interface startup_if;
    logic link_clock_out;
    logic ref_clock_in;
    logic chip_reset_n;
    logic dir;
    logic stp;
    logic sleep_req;
    logic auto_resume_wr;
    logic [startup_pkg::DATA_W-1:0] phy_data_out;
    logic phy_data_oe;
    logic [startup_pkg::DATA_W-1:0] link_data_out;
    logic link_data_oe;
    logic [startup_pkg::DATA_W-1:0] data;

    // Undriven bus reads as idle
    assign data = phy_data_oe ? phy_data_out : (link_data_oe ? link_data_out : startup_pkg::ULPI_IDLE);

    modport phy(output link_clock_out, dir, phy_data_out, phy_data_oe,
                input ref_clock_in, chip_reset_n, stp, sleep_req, auto_resume_wr, data);
    modport link(input link_clock_out, dir, phy_data_out, phy_data_oe, data,
                 output ref_clock_in, chip_reset_n, stp, sleep_req, auto_resume_wr, link_data_out, link_data_oe);
endinterface : startup_if

// ===== design/ulpi_phy_startup_sequencer.sv
/*
 Transceiver end: reset release, reference-clock lock model, DIR/STP start-up handshake,
 link clock generation and supply-dependent mode outputs.
 Assumes every pin from the link and every supply flag is asynchronous to SYS_CLK.
*/
// Notes on behaviour
// - Lock timing uses reference rising edges only.
// - Link clock derived, no phase relation required.
// - Leave reset when power-on and pin high.
// - Drive idle, hold DIR until locked.
// - After lock, see STP low before releasing.
// - STP held high keeps DIR asserted.
// - Link drives idle cycle after DIR falls.
// - Reset pin synchronised before sequencing starts.
// - Start-up interval begins at first reference edge.
// - Reference clock during reset starts nothing.
// - Reset pin low restores defaults everywhere except ANALOG_HIGH_ON, which still follows the supplies.
// - Link always drives reset pin.
// - Link holds reset until core stable.
// - Reset enters synchronous mode, auto-resume cleared.
// - Host link sets auto-resume after start-up.
// - Reference stops only after final write.
// - STP wakes low power, reference restarts.
// - Reference loss drops lock, clock to minimum.
// - No high supply: register access only.
// - No core supply: link side inactive.
`timescale 1ns/1ps
module ulpi_phy_startup_sequencer #(
    parameter int LOCK_EDGES = startup_pkg::LOCK_EDGES_DEF,
    parameter int REF_TIMEOUT = startup_pkg::REF_TIMEOUT_DEF,
    parameter int CLK_HALF_LOCKED = startup_pkg::CLK_HALF_LOCKED_DEF,
    parameter int CLK_HALF_MIN = startup_pkg::CLK_HALF_MIN_DEF
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Link pins
    startup_if.phy LINK,
    // Supply monitors
    input wire logic CORE_SUPPLY_GOOD,
    input wire logic IO_HIGH_SUPPLY_GOOD,
    // Status
    output logic PLL_LOCKED,
    output logic LINK_READY,
    output logic REG_ACCESS_ONLY,
    output logic FULL_USB_ACTIVE,
    output logic ANALOG_HIGH_ON,
    output logic HOST_RESUME_AUTO_REPLY
);
    localparam int LW = $clog2(LOCK_EDGES + 1);
    localparam int TW = $clog2(REF_TIMEOUT + 1);
    localparam int HW = $clog2(CLK_HALF_MIN + 1);
    localparam logic [LW-1:0] LOCK_FULL = LW'(LOCK_EDGES);
    localparam logic [TW-1:0] TIMEOUT = TW'(REF_TIMEOUT);
    localparam logic [HW-1:0] HALF_FAST = HW'(CLK_HALF_LOCKED - 1);
    localparam logic [HW-1:0] HALF_SLOW = HW'(CLK_HALF_MIN - 1);

    if (LOCK_EDGES < 1 || REF_TIMEOUT < 2 || CLK_HALF_LOCKED < 1 || CLK_HALF_MIN < CLK_HALF_LOCKED) begin : g_bad_params
        $error("ulpi_phy_startup_sequencer: bad parameters");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Bit order: core, io_high, reset pin, ref clock, stp, sleep, auto-resume write
    localparam int NS = 7;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] sync1_q;
    logic [NS-1:0] sync2_q;
    logic ref_prev_q;
    assign raw_in = {CORE_SUPPLY_GOOD, IO_HIGH_SUPPLY_GOOD, LINK.chip_reset_n, LINK.ref_clock_in,
                     LINK.stp, LINK.sleep_req, LINK.auto_resume_wr};

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_q <= '0;
            sync2_q <= '0;
            ref_prev_q <= 1'b0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            ref_prev_q <= sync2_q[3];
        end
    end

    logic core_ok, io_ok, pin_high, ref_level, stp_in, sleep_in, aw_in, ref_rise;
    assign core_ok = sync2_q[6];
    assign io_ok = sync2_q[5];
    assign pin_high = sync2_q[4];
    assign ref_level = sync2_q[3];
    assign stp_in = sync2_q[2];
    assign sleep_in = sync2_q[1];
    assign aw_in = sync2_q[0];
    assign ref_rise = ref_level & ~ref_prev_q;

    // ------------------------------------------------------------
    // Sequencer and lock model
    // ------------------------------------------------------------
    startup_pkg::phy_state_t state_q, state_d;
    logic [LW-1:0] lock_cnt_q, lock_cnt_d;
    logic [TW-1:0] idle_cnt_q, idle_cnt_d;
    logic locked_q, locked_d;
    logic dir_q, dir_d;
    logic data_oe_q, data_oe_d;
    logic auto_q, auto_d;
    logic ready_q, ready_d;
    logic reg_only_q, reg_only_d;
    logic full_q, full_d;
    logic analog_q, analog_d;

    always_comb begin
        state_d = state_q;
        lock_cnt_d = lock_cnt_q;
        idle_cnt_d = idle_cnt_q;
        auto_d = auto_q;
        if (ref_rise) begin
            idle_cnt_d = '0;
            if (lock_cnt_q != LOCK_FULL)
                lock_cnt_d = lock_cnt_q + LW'(1);
        end else if (idle_cnt_q == TIMEOUT) begin
            lock_cnt_d = '0;
        end else begin
            idle_cnt_d = idle_cnt_q + TW'(1);
        end
        if (!core_ok) begin
            state_d = startup_pkg::PS_OFF;
        end else if (!pin_high) begin
            state_d = startup_pkg::PS_STANDBY;
        end else begin
            unique case (state_q)
                startup_pkg::PS_OFF, startup_pkg::PS_STANDBY: begin
                    state_d = startup_pkg::PS_WAIT_LOCK;
                end
                startup_pkg::PS_WAIT_LOCK: begin
                    if (locked_q)
                        state_d = startup_pkg::PS_WAIT_STP;
                end
                startup_pkg::PS_WAIT_STP: begin
                    if (!locked_q)
                        state_d = startup_pkg::PS_WAIT_LOCK;
                    else if (!stp_in)
                        state_d = startup_pkg::PS_RUN;
                end
                startup_pkg::PS_RUN: begin
                    if (sleep_in)
                        state_d = startup_pkg::PS_LOWPWR;
                    if (aw_in)
                        auto_d = 1'b1;
                end
                startup_pkg::PS_LOWPWR: begin
                    if (stp_in)
                        state_d = startup_pkg::PS_WAIT_LOCK;
                end
                default: state_d = startup_pkg::PS_OFF;
            endcase
        end
        // Lock cannot begin before reset release
        if (state_d == startup_pkg::PS_OFF || state_d == startup_pkg::PS_STANDBY) begin
            lock_cnt_d = '0;
            idle_cnt_d = '0;
            auto_d = 1'b0;
        end
        locked_d = (lock_cnt_d == LOCK_FULL);
        dir_d = state_d inside {startup_pkg::PS_WAIT_LOCK, startup_pkg::PS_WAIT_STP, startup_pkg::PS_LOWPWR};
        data_oe_d = state_d inside {startup_pkg::PS_WAIT_LOCK, startup_pkg::PS_WAIT_STP};
        ready_d = (state_d == startup_pkg::PS_RUN);
        reg_only_d = ready_d & ~io_ok;
        full_d = ready_d & io_ok;
        analog_d = core_ok & io_ok;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= startup_pkg::PS_OFF;
            lock_cnt_q <= '0;
            idle_cnt_q <= '0;
            locked_q <= 1'b0;
            dir_q <= 1'b0;
            data_oe_q <= 1'b0;
            auto_q <= 1'b0;
            ready_q <= 1'b0;
            reg_only_q <= 1'b0;
            full_q <= 1'b0;
            analog_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lock_cnt_q <= lock_cnt_d;
            idle_cnt_q <= idle_cnt_d;
            locked_q <= locked_d;
            dir_q <= dir_d;
            data_oe_q <= data_oe_d;
            auto_q <= auto_d;
            ready_q <= ready_d;
            reg_only_q <= reg_only_d;
            full_q <= full_d;
            analog_q <= analog_d;
        end
    end

    // ------------------------------------------------------------
    // Link clock divider
    // ------------------------------------------------------------
    // Stands in for the PLL output; falls back to the slow half period when unlocked
    logic clk_q, clk_d;
    logic [HW-1:0] half_cnt_q, half_cnt_d;
    logic [HW-1:0] half_lim;

    always_comb begin
        half_lim = locked_q ? HALF_FAST : HALF_SLOW;
        clk_d = clk_q;
        half_cnt_d = half_cnt_q + HW'(1);
        if (!(state_q inside {startup_pkg::PS_WAIT_LOCK, startup_pkg::PS_WAIT_STP, startup_pkg::PS_RUN})) begin
            clk_d = 1'b0;
            half_cnt_d = '0;
        end else if (half_cnt_q >= half_lim) begin
            clk_d = ~clk_q;
            half_cnt_d = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            clk_q <= 1'b0;
            half_cnt_q <= '0;
        end else begin
            clk_q <= clk_d;
            half_cnt_q <= half_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign LINK.link_clock_out = clk_q;
    assign LINK.dir = dir_q;
    assign LINK.phy_data_out = startup_pkg::ULPI_IDLE;
    assign LINK.phy_data_oe = data_oe_q;
    assign PLL_LOCKED = locked_q;
    assign LINK_READY = ready_q;
    assign REG_ACCESS_ONLY = reg_only_q;
    assign FULL_USB_ACTIVE = full_q;
    assign ANALOG_HIGH_ON = analog_q;
    assign HOST_RESUME_AUTO_REPLY = auto_q;
endmodule : ulpi_phy_startup_sequencer

// ===== design/ulpi_link_startup_ctrl.sv
/*
 Link controller end: drives the reset pin and reference clock, completes the start-up
 handshake, requests low power and wakes the transceiver.
 Assumes link_clock_out, dir and the core supply flag are asynchronous to SYS_CLK.
*/
`timescale 1ns/1ps
module ulpi_link_startup_ctrl #(
    parameter int REF_HALF = startup_pkg::REF_HALF_DEF,
    parameter bit HOST_MODE = 1'b1
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Transceiver pins
    startup_if.link PHY,
    // User side
    input wire logic CORE_SUPPLY_GOOD,
    input wire logic LINK_ENABLE,
    input wire logic SLEEP_REQ,
    input wire logic WAKE_REQ,
    output logic STARTUP_DONE,
    output logic IN_LOW_POWER
);
    localparam int RW = $clog2(startup_pkg::RESET_LOW_MIN_CYC + 1);
    localparam logic [RW-1:0] RST_MIN = RW'(startup_pkg::RESET_LOW_MIN_CYC);
    localparam int FW = $clog2(REF_HALF + 1);
    localparam logic [FW-1:0] REF_LIM = FW'(REF_HALF - 1);
    localparam logic [1:0] STP_LIM = 2'(startup_pkg::STP_HOLD_EDGES);

    if (REF_HALF < 1) begin : g_bad_params
        $error("ulpi_link_startup_ctrl: REF_HALF must be at least 1");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_q, sync2_q;
    logic lclk_prev_q;
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_q <= '0;
            sync2_q <= '0;
            lclk_prev_q <= 1'b0;
        end else begin
            sync1_q <= {CORE_SUPPLY_GOOD, PHY.link_clock_out, PHY.dir};
            sync2_q <= sync1_q;
            lclk_prev_q <= sync2_q[1];
        end
    end
    logic core_ok, dir_in, lclk_rise;
    assign core_ok = sync2_q[2];
    assign dir_in = sync2_q[0];
    assign lclk_rise = sync2_q[1] & ~lclk_prev_q;

    // ------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------
    startup_pkg::link_state_t state_q, state_d;
    logic [RW-1:0] low_cnt_q, low_cnt_d;
    logic [1:0] stp_cnt_q, stp_cnt_d;
    logic [FW-1:0] ref_cnt_q, ref_cnt_d;
    logic ref_q, ref_d;
    logic rst_n_q, rst_n_d;
    logic stp_q, stp_d;
    logic sleep_q, sleep_d;
    logic aw_q, aw_d;
    logic oe_q, oe_d;

    always_comb begin
        state_d = state_q;
        low_cnt_d = low_cnt_q;
        stp_cnt_d = stp_cnt_q;
        if (!core_ok || !LINK_ENABLE) begin
            state_d = startup_pkg::LS_HOLD;
        end else begin
            unique case (state_q)
                startup_pkg::LS_HOLD: begin
                    if (low_cnt_q == RST_MIN)
                        state_d = startup_pkg::LS_START;
                end
                startup_pkg::LS_START: begin
                    if (dir_in)
                        state_d = startup_pkg::LS_TURN;
                end
                startup_pkg::LS_TURN: begin
                    if (lclk_rise && !dir_in)
                        state_d = startup_pkg::LS_ACTIVE;
                end
                startup_pkg::LS_ACTIVE: begin
                    if (SLEEP_REQ)
                        state_d = startup_pkg::LS_SLEEP;
                end
                startup_pkg::LS_SLEEP: begin
                    if (dir_in)
                        state_d = startup_pkg::LS_DOZE;
                end
                startup_pkg::LS_DOZE: begin
                    if (WAKE_REQ)
                        state_d = startup_pkg::LS_WAKE;
                end
                startup_pkg::LS_WAKE: begin
                    if (lclk_rise)
                        stp_cnt_d = stp_cnt_q + 2'd1;
                    if (stp_cnt_q == STP_LIM)
                        state_d = startup_pkg::LS_START;
                end
                default: state_d = startup_pkg::LS_HOLD;
            endcase
        end
        if (state_d != startup_pkg::LS_HOLD)
            low_cnt_d = '0;
        else if (low_cnt_q != RST_MIN)
            low_cnt_d = low_cnt_q + RW'(1);
        if (state_d != startup_pkg::LS_WAKE)
            stp_cnt_d = '0;
        rst_n_d = (state_d != startup_pkg::LS_HOLD);
        stp_d = (state_d == startup_pkg::LS_WAKE);
        sleep_d = state_d inside {startup_pkg::LS_SLEEP, startup_pkg::LS_DOZE};
        aw_d = HOST_MODE && (state_d == startup_pkg::LS_ACTIVE);
        oe_d = (state_d == startup_pkg::LS_ACTIVE);
        // Reference stopped in reset hold and in doze; it still runs in sleep
        ref_cnt_d = ref_cnt_q + FW'(1);
        ref_d = ref_q;
        if (state_d inside {startup_pkg::LS_HOLD, startup_pkg::LS_DOZE}) begin
            ref_d = 1'b0;
            ref_cnt_d = '0;
        end else if (ref_cnt_q >= REF_LIM) begin
            ref_d = ~ref_q;
            ref_cnt_d = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= startup_pkg::LS_HOLD;
            low_cnt_q <= '0;
            stp_cnt_q <= '0;
            ref_cnt_q <= '0;
            ref_q <= 1'b0;
            rst_n_q <= 1'b0;
            stp_q <= 1'b0;
            sleep_q <= 1'b0;
            aw_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            low_cnt_q <= low_cnt_d;
            stp_cnt_q <= stp_cnt_d;
            ref_cnt_q <= ref_cnt_d;
            ref_q <= ref_d;
            rst_n_q <= rst_n_d;
            stp_q <= stp_d;
            sleep_q <= sleep_d;
            aw_q <= aw_d;
            oe_q <= oe_d;
        end
    end

    assign PHY.chip_reset_n = rst_n_q;
    assign PHY.ref_clock_in = ref_q;
    assign PHY.stp = stp_q;
    assign PHY.sleep_req = sleep_q;
    assign PHY.auto_resume_wr = aw_q;
    assign PHY.link_data_out = startup_pkg::ULPI_IDLE;
    assign PHY.link_data_oe = oe_q;
    assign STARTUP_DONE = oe_q;
    assign IN_LOW_POWER = sleep_q;
endmodule : ulpi_link_startup_ctrl

// ===== dv/startup_assertions.sv
/*
 Checker for the start-up pins between transceiver and link controller.
 Assumes the bench hands it the interface signals and the shared clock and reset.
*/
`timescale 1ns/1ps
module startup_checker (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Interface pins
    input wire logic link_clock_out,
    input wire logic chip_reset_n,
    input wire logic dir,
    input wire logic stp,
    input wire logic [startup_pkg::DATA_W-1:0] phy_data_out,
    input wire logic phy_data_oe,
    input wire logic link_data_oe,
    input wire logic [startup_pkg::DATA_W-1:0] data
);
    // ------------------------------------------------------------
    // Reset pin low-time counter
    // ------------------------------------------------------------
    // One sample of slack: the release edge itself may not be counted
    localparam int LOW_MIN = startup_pkg::RESET_LOW_MIN_CYC - 1;
    logic [7:0] low_q;
    logic [7:0] low_d;

    always_comb begin
        low_d = chip_reset_n ? 8'h00 : ((low_q == 8'hff) ? low_q : low_q + 8'h01);
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_d;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_pin_low;
        !chip_reset_n [*5];
    endsequence
    sequence s_stp_hold;
        (dir && stp && chip_reset_n) [*6];
    endsequence

    a_reset_quiet: assert property (s_pin_low |-> !dir && !phy_data_oe && !link_clock_out)
        else $error("transceiver active while reset pin low");
    a_bus_idle_wait: assert property (dir && phy_data_oe |-> phy_data_out == startup_pkg::ULPI_IDLE)
        else $error("transceiver drives non-idle data during start-up");
    a_oe_with_dir: assert property (phy_data_oe |-> dir)
        else $error("transceiver drives bus without dir");
    a_stp_keeps_dir: assert property (s_stp_hold |=> dir)
        else $error("dir released while stp high");
    a_release_stp_low: assert property ($fell(dir) |-> $past(stp, 1) == 1'b0 && $past(stp, 2) == 1'b0)
        else $error("dir released without stp low");
    a_link_idle_turn: assert property ($rose(link_data_oe) |-> !dir && data == startup_pkg::ULPI_IDLE)
        else $error("link idle not driven after turnaround");
    a_turn_bound: assert property ($fell(dir) |-> ##[0:16] link_data_oe)
        else $error("link did not take bus after dir fell");
    a_reset_low_len: assert property ($rose(chip_reset_n) |-> low_q >= LOW_MIN)
        else $error("reset pin low time too short");
    a_clock_runs_wait: assert property (phy_data_oe |-> ##[1:5] ($changed(link_clock_out) || !phy_data_oe))
        else $error("link clock not toggling during start-up");
endmodule : startup_checker

// ===== dv/ulpi_phy_startup_sequencer_tb.sv
/*
 Self-checking bench joining transceiver and link controller through startup_if.
 Assumes both ends share one 40 MHz clock; the link end makes the reference clock.
*/
`timescale 1ns/1ps
module ulpi_phy_startup_sequencer_tb;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam int S_DIR = 0, S_RDY = 1, S_LCK = 2, S_DONE = 3, S_LP = 4, S_HRA = 5;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic core = 1'b1;
    logic io = 1'b1;
    logic en = 1'b0;
    logic slp = 1'b0;
    logic wk = 1'b0;
    logic pll_locked, link_ready, reg_only, full_usb, analog_on, auto_reply, done, low_pwr;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    startup_if startup_if_inst ();

    // Short lock count keeps each start-up brief
    ulpi_phy_startup_sequencer #(.LOCK_EDGES(4)) ulpi_phy_startup_sequencer_inst (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .LINK(startup_if_inst),
        .CORE_SUPPLY_GOOD(core), .IO_HIGH_SUPPLY_GOOD(io),
        .PLL_LOCKED(pll_locked), .LINK_READY(link_ready), .REG_ACCESS_ONLY(reg_only),
        .FULL_USB_ACTIVE(full_usb), .ANALOG_HIGH_ON(analog_on), .HOST_RESUME_AUTO_REPLY(auto_reply)
    );

    ulpi_link_startup_ctrl ulpi_link_startup_ctrl_inst (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .PHY(startup_if_inst),
        .CORE_SUPPLY_GOOD(core), .LINK_ENABLE(en), .SLEEP_REQ(slp), .WAKE_REQ(wk),
        .STARTUP_DONE(done), .IN_LOW_POWER(low_pwr)
    );

    startup_checker startup_checker_inst (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .link_clock_out(startup_if_inst.link_clock_out),
        .chip_reset_n(startup_if_inst.chip_reset_n), .dir(startup_if_inst.dir), .stp(startup_if_inst.stp),
        .phy_data_out(startup_if_inst.phy_data_out), .phy_data_oe(startup_if_inst.phy_data_oe),
        .link_data_oe(startup_if_inst.link_data_oe), .data(startup_if_inst.data)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t level mismatch got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_bus(input logic [startup_pkg::DATA_W-1:0] got, input logic [startup_pkg::DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t bus mismatch got %h expected %h", $time, got, exp);
        end
    endtask : chk_bus

    function automatic logic pick(input int s);
        case (s)
            S_DIR: return startup_if_inst.dir;
            S_RDY: return link_ready;
            S_LCK: return pll_locked;
            S_DONE: return done;
            S_LP: return low_pwr;
            default: return auto_reply;
        endcase
    endfunction : pick

    // Bounded wait on a status level, then compare it
    task automatic wait_for(input int s, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && pick(s) !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk_bit(pick(s), v);
    endtask : wait_for

    task automatic set_in(input logic c, input logic i, input logic e, input logic s, input logic w);
        @(posedge sys_clk);
        #2;
        core = c;
        io = i;
        en = e;
        slp = s;
        wk = w;
    endtask : set_in

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic startup();
        wait_for(S_DIR, 1'b1, 120);
        chk_bit(startup_if_inst.chip_reset_n, 1'b1);
        chk_bus(startup_if_inst.data, startup_pkg::ULPI_IDLE);
        chk_bit(auto_reply, 1'b0);
        wait_for(S_LCK, 1'b1, 200);
        wait_for(S_RDY, 1'b1, 100);
        chk_bit(startup_if_inst.dir, 1'b0);
        chk_bit(startup_if_inst.stp, 1'b0);
        wait_for(S_DONE, 1'b1, 40);
        chk_bus(startup_if_inst.data, startup_pkg::ULPI_IDLE);
        wait_for(S_HRA, 1'b1, 20);
        chk_bit(full_usb, 1'b1);
        chk_bit(reg_only, 1'b0);
    endtask : startup

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        settle(2);
        #1;
        rst_b = 1'b1;
        // Link held off: nothing may start
        settle(60);
        chk_bit(startup_if_inst.dir, 1'b0);
        chk_bit(startup_if_inst.chip_reset_n, 1'b0);
        chk_bit(pll_locked, 1'b0);
        set_in(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        startup();
        set_in(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        settle(8);
        chk_bit(reg_only, 1'b1);
        chk_bit(full_usb, 1'b0);
        chk_bit(analog_on, 1'b0);
        set_in(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        settle(8);
        chk_bit(analog_on, 1'b1);
        // Low power entry, reference stopped, then wake
        set_in(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        wait_for(S_LP, 1'b1, 20);
        wait_for(S_DIR, 1'b1, 40);
        chk_bit(link_ready, 1'b0);
        wait_for(S_LCK, 1'b0, 60);
        set_in(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        wait_for(S_RDY, 1'b1, 400);
        chk_bit(pll_locked, 1'b1);
        set_in(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        wait_for(S_DONE, 1'b1, 40);
        // Core supply loss clears everything, then a full restart
        set_in(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        settle(10);
        chk_bit(link_ready, 1'b0);
        chk_bit(analog_on, 1'b0);
        chk_bit(startup_if_inst.dir, 1'b0);
        chk_bit(auto_reply, 1'b0);
        set_in(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        startup();
        wrap_up();
    end
endmodule : ulpi_phy_startup_sequencer_tb
